// file: design/ife_interrupt_flag_enable_regs.sv
// Interrupt request flag registers 0-4, enable register 0, and a sticky
// flag-arrival status with mask and one level interrupt output.
// Assumes peripheral requests are on sys_clk; external pins are async.
// Operation
// - Flag register 0 holds ADC done at 13, UART tx 12, UART rx 11, SPI event 10, SPI error 9, timer3 8.
// - Flag register 0 holds timer2 at 7, compare2 6, capture2 5, timer1 3, compare1 2, capture1 1, ext input0 0, bit 4 unused.
// - Flag register 1 holds ext input2 at 13, timer5 12, timer4 11, ext input1 4, change 3, comparator 2, I2C master 1, I2C slave 0.
// - Timer5 and timer4 flags exist only in the larger-flash variant.
// - Flag register 2 holds only capture3 at bit 5.
// - Flag register 3 holds PWM fault A at 15, RTC at 14, PWM period at 9.
// - Flag register 4 holds charge-time unit at 13, UART error at 1, PWM fault B at 0.
// - The PWM fault B flag is absent in the smallest package variant.
// - An implemented flag reads 1 once its request has occurred, else 0.
// - Enable register 0 mirrors flag register 0, bits 15, 14 and 4 unused.
// - An enable bit at 1 lets its request through and at 0 blocks it.
// - Unimplemented bits ignore writes and read as zero.
// - Implemented flag and enable bits are read/write and reset to zero.
// - Hardware sets a flag on request; only software clears it.
// - A source has the same bit index in flag and enable registers.
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/100ps
module ife_interrupt_flag_enable_regs #(
    parameter bit LARGE_FLASH = 1'b1,
    parameter bit HAS_FAULT_B = 1'b1
) (
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    input  wire logic                  clk_en,
    input  wire ife_pkg::ife_bus_s     bus,
    output logic [ife_pkg::REG_W-1:0]  rdata,
    input  wire ife_pkg::ife_flags_t   periph_req,
    input  wire logic [ife_pkg::EXT_NUM-1:0] ext_pin,
    output ife_pkg::ife_flags_t        flags,
    output logic [ife_pkg::REG_W-1:0]  enables0,
    output logic [ife_pkg::REG_W-1:0]  arb_request,
    output logic                       irq
);

    // Implemented bits of one flag register, per variant
    function automatic logic [ife_pkg::REG_W-1:0] impl_mask(input int idx);
        logic [ife_pkg::REG_W-1:0] m;
        m = ife_pkg::RST_VALUE;
        case (idx)
            0: m = ife_pkg::IMPL_FLAGS0;
            1: begin
                m = ife_pkg::IMPL_FLAGS1;
                if (LARGE_FLASH)
                    m = m | ife_pkg::TIMER45_BITS;
            end
            2: m = ife_pkg::IMPL_FLAGS2;
            3: m = ife_pkg::IMPL_FLAGS3;
            4: begin
                m = ife_pkg::IMPL_FLAGS4;
                if (HAS_FAULT_B)
                    m = m | ife_pkg::FAULT_B_BIT;
            end
            default: m = ife_pkg::RST_VALUE;
        endcase
        return m;
    endfunction : impl_mask

    function automatic logic wr_hit(input logic [ife_pkg::ADDR_W-1:0] off);
        return bus.wr && (bus.addr == off);
    endfunction : wr_hit

    // External pin synchroniser; stage 0 feeds only stage 1
    logic [ife_pkg::EXT_NUM-1:0] sync0;
    logic [ife_pkg::EXT_NUM-1:0] sync1;
    logic [ife_pkg::EXT_NUM-1:0] sync_prev;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync0     <= '0;
            sync1     <= '0;
            sync_prev <= '0;
        end else if (clk_en) begin
            sync0     <= ext_pin;
            sync1     <= sync0;
            sync_prev <= sync1;
        end
    end

    // Rising edge only: edge polarity selection lives outside this block
    logic [ife_pkg::EXT_NUM-1:0] ext_rise;
    assign ext_rise = sync1 & ~sync_prev;

    logic [ife_pkg::STATUS_W-1:0] irq_status;
    logic [ife_pkg::STATUS_W-1:0] irq_mask;

    ife_pkg::ife_flags_t               next_flags;
    ife_pkg::ife_flags_t               hw_set;
    logic [ife_pkg::REG_W-1:0]         next_enables0;
    logic [ife_pkg::STATUS_W-1:0]      next_irq_status;
    logic [ife_pkg::STATUS_W-1:0]      next_irq_mask;
    logic [ife_pkg::REG_W-1:0]         next_rdata;
    logic [ife_pkg::REG_W-1:0]         read_mux;

    always_comb begin
        hw_set = periph_req;
        hw_set[ife_pkg::EXT0_REG][ife_pkg::EXT_INPUT0_POS] =
            periph_req[ife_pkg::EXT0_REG][ife_pkg::EXT_INPUT0_POS] |
            ext_rise[0];
        hw_set[ife_pkg::EXT1_REG][ife_pkg::EXT_INPUT1_POS] =
            periph_req[ife_pkg::EXT1_REG][ife_pkg::EXT_INPUT1_POS] |
            ext_rise[1];
        hw_set[ife_pkg::EXT2_REG][ife_pkg::EXT_INPUT2_POS] =
            periph_req[ife_pkg::EXT2_REG][ife_pkg::EXT_INPUT2_POS] |
            ext_rise[2];

        next_flags      = flags;
        next_irq_status = irq_status;
        for (int r = 0; r < ife_pkg::FLAG_REGS; r++) begin
            hw_set[r] = hw_set[r] & impl_mask(r);
            if (wr_hit(ife_pkg::OFF_FLAGS0 + ife_pkg::ADDR_W'(r)))
                next_flags[r] = bus.wdata & impl_mask(r);
            // Set after the write so a same-cycle clear loses
            next_flags[r] = next_flags[r] | hw_set[r];
        end

        next_enables0 = enables0;
        if (wr_hit(ife_pkg::OFF_ENABLES0))
            next_enables0 = bus.wdata & impl_mask(0);

        // Status: one sticky bit per flag register, write one to clear
        if (wr_hit(ife_pkg::OFF_IRQ_STATUS))
            next_irq_status = irq_status &
                ~bus.wdata[ife_pkg::STATUS_W-1:0];
        for (int r = 0; r < ife_pkg::FLAG_REGS; r++) begin
            if (|hw_set[r])
                next_irq_status[r] = 1'b1;
        end

        next_irq_mask = irq_mask;
        if (wr_hit(ife_pkg::OFF_IRQ_MASK))
            next_irq_mask = bus.wdata[ife_pkg::STATUS_W-1:0];

        read_mux = ife_pkg::RST_VALUE;
        if (bus.addr <= ife_pkg::OFF_FLAGS4)
            read_mux = flags[bus.addr];
        else if (bus.addr == ife_pkg::OFF_ENABLES0)
            read_mux = enables0;
        else if (bus.addr == ife_pkg::OFF_IRQ_STATUS)
            read_mux = {{(ife_pkg::REG_W-ife_pkg::STATUS_W){1'b0}},
                        irq_status};
        else
            read_mux = {{(ife_pkg::REG_W-ife_pkg::STATUS_W){1'b0}},
                        irq_mask};
        // Read data stands for one cycle only, zero otherwise
        next_rdata = bus.rd ? read_mux : ife_pkg::RST_VALUE;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int r = 0; r < ife_pkg::FLAG_REGS; r++)
                flags[r] <= ife_pkg::RST_VALUE;
            enables0   <= ife_pkg::RST_VALUE;
            irq_status <= ife_pkg::RST_STATUS;
            irq_mask   <= ife_pkg::RST_STATUS;
            rdata      <= ife_pkg::RST_VALUE;
        end else if (clk_en) begin
            flags      <= next_flags;
            enables0   <= next_enables0;
            irq_status <= next_irq_status;
            irq_mask   <= next_irq_mask;
            rdata      <= next_rdata;
        end
    end

    assign arb_request = flags[0] & enables0;
    assign irq         = |(irq_status & irq_mask);

endmodule : ife_interrupt_flag_enable_regs

// file: design/ife_pkg.sv
// Constants, types and register map of the interrupt flag and enable block.
// Assumes a single system clock and a plain strobe register port.
package ife_pkg;

    localparam int REG_W      = 16;
    localparam int ADDR_W     = 3;
    localparam int FLAG_REGS  = 5;
    localparam int EXT_NUM    = 3;
    localparam int STATUS_W   = 5;

    typedef logic [FLAG_REGS-1:0][REG_W-1:0] ife_flags_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [REG_W-1:0]  wdata;
        logic              wr;
        logic              rd;
    } ife_bus_s;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFF_FLAGS0     = 3'h0;
    localparam logic [ADDR_W-1:0] OFF_FLAGS4     = 3'h4;
    localparam logic [ADDR_W-1:0] OFF_ENABLES0   = 3'h5;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 3'h6;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK   = 3'h7;

    // Flag positions, register 0 (enable register 0 uses the same ones)
    localparam int ADC_DONE_POS   = 13;
    localparam int UART_TX_POS    = 12;
    localparam int UART_RX_POS    = 11;
    localparam int SPI_EVENT_POS  = 10;
    localparam int SPI_ERROR_POS  = 9;
    localparam int TIMER3_POS     = 8;
    localparam int TIMER2_POS     = 7;
    localparam int COMPARE2_POS   = 6;
    localparam int CAPTURE2_POS   = 5;
    localparam int TIMER1_POS     = 3;
    localparam int COMPARE1_POS   = 2;
    localparam int CAPTURE1_POS   = 1;
    localparam int EXT_INPUT0_POS = 0;
    // Register 1
    localparam int EXT_INPUT2_POS = 13;
    localparam int TIMER5_POS     = 12;
    localparam int TIMER4_POS     = 11;
    localparam int EXT_INPUT1_POS = 4;
    localparam int CHANGE_POS     = 3;
    localparam int COMPARATOR_POS = 2;
    localparam int I2C_MASTER_POS = 1;
    localparam int I2C_SLAVE_POS  = 0;
    // Registers 2 to 4
    localparam int CAPTURE3_POS   = 5;
    localparam int FAULT_A_POS    = 15;
    localparam int RTC_POS        = 14;
    localparam int PWM_PERIOD_POS = 9;
    localparam int CHARGE_POS     = 13;
    localparam int UART_ERR_POS   = 1;
    localparam int FAULT_B_POS    = 0;

    // Register that each external input lands in
    localparam int EXT0_REG = 0;
    localparam int EXT1_REG = 1;
    localparam int EXT2_REG = 1;

    // Implemented-bit masks
    localparam logic [REG_W-1:0] IMPL_FLAGS0     = 16'h3FEF;
    localparam logic [REG_W-1:0] IMPL_FLAGS1     = 16'h201F;
    localparam logic [REG_W-1:0] TIMER45_BITS    = 16'h1800;
    localparam logic [REG_W-1:0] IMPL_FLAGS2     = 16'h0020;
    localparam logic [REG_W-1:0] IMPL_FLAGS3     = 16'hC200;
    localparam logic [REG_W-1:0] IMPL_FLAGS4     = 16'h2002;
    localparam logic [REG_W-1:0] FAULT_B_BIT     = 16'h0001;
    localparam logic [REG_W-1:0] RST_VALUE       = 16'h0000;
    localparam logic [STATUS_W-1:0] RST_STATUS   = 5'h00;

endpackage : ife_pkg

// file: test/ife_chk.sv
// Port-level checker for the interrupt flag and enable block.
// Assumes one clock domain; bound onto every instance of the block.
`timescale 1ns/100ps
module ife_chk (
    input wire logic                sys_clk,
    input wire logic                rst_n,
    input wire logic                clk_en,
    input wire ife_pkg::ife_bus_s   bus,
    input wire logic [15:0]         rdata,
    input wire ife_pkg::ife_flags_t periph_req,
    input wire ife_pkg::ife_flags_t flags,
    input wire logic [15:0]         enables0,
    input wire logic [15:0]         arb_request
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_arb_gate: assert property (arb_request == (flags[0] & enables0))
        else $error("arbitration request not flag and enable");
    a_unimpl_zero: assert property (((flags[0] | enables0)
        & ~ife_pkg::IMPL_FLAGS0) == 16'h0000)
        else $error("unimplemented bit set");
    a_hw_set: assert property (clk_en && periph_req[3][15]
        |=> flags[3][15])
        else $error("flag not set by request");
    a_flag_hold: assert property (clk_en && flags[4][13] && !bus.wr
        |=> flags[4][13])
        else $error("flag cleared without software");
    a_set_wins: assert property (clk_en && periph_req[0][3] && bus.wr
        && bus.addr == ife_pkg::OFF_FLAGS0 |=> flags[0][3])
        else $error("set lost to clearing write");
    a_rd_answer: assert property (clk_en && bus.rd
        && bus.addr == ife_pkg::OFF_ENABLES0
        |=> rdata == $past(enables0))
        else $error("read data wrong");
    a_rd_idle: assert property (clk_en && !bus.rd |=> rdata == 16'h0000)
        else $error("read data outside read");
    a_no_spurious: assert property (clk_en && !periph_req[2][5] && !bus.wr
        |=> !$rose(flags[2][5]))
        else $error("flag rose without cause");
endmodule : ife_chk

bind ife_interrupt_flag_enable_regs ife_chk u_chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .bus(bus),
    .rdata(rdata), .periph_req(periph_req), .flags(flags),
    .enables0(enables0), .arb_request(arb_request)
);

// file: test/ife_periph_model.sv
// Peripheral and external pin side: raises request pulses and pin edges.
// Assumes calls start just after a rising edge, one at a time.
`timescale 1ns/100ps
module ife_periph_model (
    input  wire logic               sys_clk,
    output ife_pkg::ife_flags_t     periph_req,
    output logic [2:0]              ext_pin
);
    initial begin
        periph_req = '0;
        ext_pin = 3'h0;
    end
    task pulse(input int r, input int b);
        periph_req[r][b] <= 1'b1;
        @(posedge sys_clk);
        periph_req[r][b] <= 1'b0;
    endtask : pulse
    // Held past the synchroniser so the edge is seen exactly once
    task ext_rise(input int n);
        ext_pin[n] <= 1'b1;
        repeat (4) @(posedge sys_clk);
        ext_pin[n] <= 1'b0;
    endtask : ext_rise
endmodule : ife_periph_model

// file: test/ife_interrupt_flag_enable_regs_tb_top.sv
// Self-checking bench for the interrupt flag and enable block.
// Assumes the partner model and the bound checker are compiled alongside.
`timescale 1ns/100ps
module ife_interrupt_flag_enable_regs_tb_top;
    logic                sys_clk;
    logic                rst_n;
    logic                clk_en;
    ife_pkg::ife_bus_s   bus;
    logic [15:0]         rdata, arb_request, enables0, d, e;
    ife_pkg::ife_flags_t periph_req, flags;
    logic [2:0]          ext_pin;
    logic                irq, pend;
    logic [15:0]         m [6];
    logic [15:0]         q [$];
    int                  errors, check_count;

    always #20 sys_clk = ~sys_clk;

    ife_interrupt_flag_enable_regs dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .bus(bus),
        .rdata(rdata), .periph_req(periph_req), .ext_pin(ext_pin),
        .flags(flags), .enables0(enables0), .arb_request(arb_request),
        .irq(irq));
    ife_periph_model pm (.sys_clk(sys_clk), .periph_req(periph_req),
        .ext_pin(ext_pin));

    task cmp(input logic [15:0] g, input logic [15:0] x);
        check_count++;
        if (g !== x) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask : cmp
    task wr(input logic [2:0] a, input logic [15:0] v);
        bus.addr <= a;
        bus.wdata <= v;
        bus.wr <= 1'b1;
        @(posedge sys_clk);
        bus.wr <= 1'b0;
        // One idle edge so a following call never re-drives in this step
        @(posedge sys_clk);
    endtask : wr
    task rd(input logic [2:0] a, input logic [15:0] x);
        q.push_back(x);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge sys_clk);
        bus.rd <= 1'b0;
        @(posedge sys_clk);
    endtask : rd
    task lvl(input logic x);
        @(negedge sys_clk);
        cmp({15'h0000, irq}, {15'h0000, x});
        @(posedge sys_clk);
    endtask : lvl
    task close_out;
        $display("errors=%0d checks=%0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out

    // Read data belongs to the strobe of the previous cycle
    always @(posedge sys_clk) begin
        if (pend) begin
            cmp(rdata, q.pop_front());
        end
        pend <= bus.rd;
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        close_out;
    end

    initial begin
        sys_clk = 1'b0;
        rst_n = 1'b0;
        clk_en = 1'b1;
        bus = '0;
        pend = 1'b0;
        m = '{ife_pkg::IMPL_FLAGS0,
              ife_pkg::IMPL_FLAGS1 | ife_pkg::TIMER45_BITS,
              ife_pkg::IMPL_FLAGS2, ife_pkg::IMPL_FLAGS3,
              ife_pkg::IMPL_FLAGS4 | ife_pkg::FAULT_B_BIT,
              ife_pkg::IMPL_FLAGS0};
        void'($urandom(32'h6DB9ECBF));
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        for (int a = 0; a < 8; a++) rd(a[2:0], 16'h0000);
        for (int r = 0; r < 6; r++) begin
            d = $urandom();
            wr(r[2:0], 16'hFFFF);
            rd(r[2:0], m[r]);
            wr(r[2:0], d);
            rd(r[2:0], d & m[r]);
        end
        e = $urandom();
        wr(ife_pkg::OFF_ENABLES0, e);
        wr(ife_pkg::OFF_FLAGS0, d);
        @(negedge sys_clk);
        cmp(arb_request, d & e & m[0]);
        @(posedge sys_clk);
        for (int r = 0; r < 5; r++) begin
            wr(r[2:0], 16'h0000);
            for (int b = 0; b < 16; b++) begin
                pm.pulse(r, b);
                rd(r[2:0], m[r] & (16'h0001 << b));
                wr(r[2:0], 16'h0000);
            end
        end
        pm.ext_rise(0);
        rd(ife_pkg::OFF_FLAGS0, 16'h0001);
        pm.ext_rise(2);
        rd(3'h1, 16'h2000);
        wr(ife_pkg::OFF_IRQ_STATUS, 16'h001F);
        pm.pulse(2, 5);
        rd(ife_pkg::OFF_IRQ_STATUS, 16'h0004);
        lvl(1'b0);
        wr(ife_pkg::OFF_IRQ_MASK, 16'h0004);
        lvl(1'b1);
        wr(ife_pkg::OFF_IRQ_STATUS, 16'h0004);
        lvl(1'b0);
        wr(ife_pkg::OFF_FLAGS0, 16'h0000);
        fork
            pm.pulse(0, 3);
            wr(ife_pkg::OFF_FLAGS0, 16'h0000);
        join
        rd(ife_pkg::OFF_FLAGS0, 16'h0008);
        // A frozen block must drop a strobe given while clk_en is low
        clk_en <= 1'b0;
        wr(ife_pkg::OFF_FLAGS0, 16'h0001);
        clk_en <= 1'b1;
        rd(ife_pkg::OFF_FLAGS0, 16'h0008);
        repeat (2) @(posedge sys_clk);
        close_out;
    end
endmodule : ife_interrupt_flag_enable_regs_tb_top
